// >>> hw/link_sync.sv
// Two-flip-flop synchroniser for a group of link pins.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module link_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_r[i] <= INIT[i];
          q[i]      <= INIT[i];
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

// >>> hw/serial_cfg_ctrl.sv
// Controller end of the serial configuration port, ordered by software over APB.
// Assumes an APB master on the same clock; the link clock is made here by a divider.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module serial_cfg_ctrl (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  serial_cfg_if.ctrl       link
);
  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic        acc;
  logic        busy;
  logic        cmd_go;
  logic        rst_go;
  logic        par_off;
  logic        parallel_r;
  logic [15:0] cmd_r;
  logic [7:0]  rd_data_r;
  serial_cfg_pkg::ctl_state_t state_r;

  assign acc     = psel && penable;
  assign pready  = 1'b1;
  assign busy    = (state_r != serial_cfg_pkg::CTL_IDLE);
  assign cmd_go  = acc && pwrite && (paddr == `APB_CMD) && !busy && !parallel_r;
  assign rst_go  = acc && pwrite && (paddr == `APB_CTRL) && !busy && pwdata[`CTRL_HW_RST_BIT];
  assign par_off = acc && pwrite && (paddr == `APB_CTRL) && !busy && parallel_r && !pwdata[`CTRL_PARALLEL_BIT];
  assign pslverr = acc && (paddr != `APB_CMD) && (paddr != `APB_CTRL) && (paddr != `APB_STATUS);

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `APB_CMD: begin
        prdata[15:0] = cmd_r;
      end
      `APB_CTRL: begin
        prdata[`CTRL_PARALLEL_BIT] = parallel_r;
      end
      `APB_STATUS: begin
        prdata[7:0]              = rd_data_r;
        prdata[`STATUS_BUSY_BIT] = busy;
      end
      default: begin
        prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_r <= 16'h0000;
    end else if (cmd_go) begin
      cmd_r <= pwdata[15:0]; // R5 R18
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      parallel_r <= 1'b0;
    end else if (acc && pwrite && (paddr == `APB_CTRL) && !busy) begin
      parallel_r <= pwdata[`CTRL_PARALLEL_BIT]; // R15
    end
  end

  // ****************************************************************
  // Link sequencer
  // ****************************************************************
  logic       s_rb;
  logic [7:0] tmr_r;
  logic [3:0] bit_r;
  logic       sclk_r;
  logic       tmr_end;

  link_sync #(
    .W    (1),
    .INIT (1'h0)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (link.readback_output),
    .q       (s_rb)
  );

  always_comb begin
    tmr_end = 1'b0;
    case (state_r)
      serial_cfg_pkg::CTL_RST_HIGH: tmr_end = (tmr_r == 8'(`RST_PULSE_CYC - 1)); // R11
      serial_cfg_pkg::CTL_RST_WAIT: tmr_end = (tmr_r == 8'(`RST_TO_SEN_CYC - 1)); // R13
      serial_cfg_pkg::CTL_SETUP:    tmr_end = (tmr_r == 8'(`SCLK_HALF_CYC - 1));
      serial_cfg_pkg::CTL_SHIFT:    tmr_end = (tmr_r == 8'(`SCLK_HALF_CYC - 1)); // R10
      serial_cfg_pkg::CTL_HOLD:     tmr_end = (tmr_r == 8'(`SEN_SETUP_CYC - 1));
      default:                      tmr_end = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || tmr_end || state_r == serial_cfg_pkg::CTL_IDLE) begin
      tmr_r <= 8'h00;
    end else begin
      tmr_r <= tmr_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= serial_cfg_pkg::CTL_IDLE;
    end else begin
      case (state_r)
        serial_cfg_pkg::CTL_IDLE: begin
          if (rst_go) begin
            state_r <= serial_cfg_pkg::CTL_RST_HIGH; // R14
          end else if (cmd_go) begin
            state_r <= serial_cfg_pkg::CTL_SETUP;
          end else if (par_off) begin
            state_r <= serial_cfg_pkg::CTL_RST_WAIT; // R13
          end
        end
        serial_cfg_pkg::CTL_RST_HIGH: if (tmr_end) state_r <= serial_cfg_pkg::CTL_RST_WAIT;
        serial_cfg_pkg::CTL_RST_WAIT: if (tmr_end) state_r <= serial_cfg_pkg::CTL_IDLE;
        serial_cfg_pkg::CTL_SETUP:    if (tmr_end) state_r <= serial_cfg_pkg::CTL_SHIFT;
        serial_cfg_pkg::CTL_SHIFT: begin
          if (tmr_end && sclk_r && bit_r == `FRAME_LAST_BIT) begin
            state_r <= serial_cfg_pkg::CTL_HOLD;
          end
        end
        serial_cfg_pkg::CTL_HOLD:     if (tmr_end) state_r <= serial_cfg_pkg::CTL_IDLE;
        default:                      state_r <= serial_cfg_pkg::CTL_IDLE;
      endcase
    end
  end

  // The clock rises after a low half with data steady and falls after a high half.
  always_ff @(posedge clk) begin
    if (sys_rst || state_r != serial_cfg_pkg::CTL_SHIFT) begin
      sclk_r <= 1'b0;
    end else if (tmr_end) begin
      sclk_r <= !sclk_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state_r != serial_cfg_pkg::CTL_SHIFT) begin
      bit_r <= 4'h0;
    end else if (tmr_end && sclk_r) begin
      bit_r <= bit_r + 4'h1;
    end
  end

  // Readback bits are taken as the link clock falls, address byte skipped.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_r <= 8'h00;
    end else if (state_r == serial_cfg_pkg::CTL_SHIFT && tmr_end && sclk_r && bit_r >= `RB_SHIFT_FIRST) begin
      rd_data_r <= {rd_data_r[6:0], s_rb}; // R7 R21
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.sclk              <= 1'b0;
      link.serial_select_low <= 1'b1;
      link.shift_data_in     <= 1'b0;
      link.reset_pin         <= 1'b0;
    end else begin
      link.sclk              <= sclk_r;
      link.serial_select_low <= !(state_r == serial_cfg_pkg::CTL_SETUP || state_r == serial_cfg_pkg::CTL_SHIFT
                                  || state_r == serial_cfg_pkg::CTL_HOLD);
      // Data moves only once the pin clock is already low, so it holds past the sampled falling edge.
      if (state_r == serial_cfg_pkg::CTL_SHIFT && !link.sclk) begin
        link.shift_data_in <= cmd_r[4'hf - bit_r]; // R18
      end else if (state_r != serial_cfg_pkg::CTL_SHIFT && state_r != serial_cfg_pkg::CTL_HOLD) begin
        link.shift_data_in <= 1'b0;
      end
      link.reset_pin         <= parallel_r || (state_r == serial_cfg_pkg::CTL_RST_HIGH); // R11 R15
    end
  end
endmodule

// >>> hw/serial_cfg_device.sv
// Converter end of the serial configuration port: frame receiver, register file and readback.
// Assumes link pins are asynchronous to clk and the link clock is slower than clk / 6.
//
// Overview of operation
// [R1] Writing one to readback bit enters readback.
// [R2] Readback mode blocks writes except register zero.
// [R3] Writing zero to readback bit reenables writes.
// [R4] Register zero reads no valid data in readback.
// [R5] Controller reads with ordinary frame giving address.
// [R6] Addressed register shifts out on readback output.
// [R7] Controller captures readback bits on falling edge.
// [R8] Readback output driven low when mode off.
// [R9] Readback independent of output interface kind.
// [R10] Shift clock at most 20 MHz, any lower.
// [R11] Reset pulse high 10 ns to 1 us.
// [R12] Reset over 1 us briefly enters parallel mode.
// [R13] Wait 100 ns after reset before select.
// [R14] Serial mode initialisation uses one reset pulse.
// [R15] Parallel configuration holds reset pin high permanently.
// [R16] Register zero: soft reset D7, readback D0.
// [R17] Data sampled on falling edge while selected.
// [R18] Frame: eight address bits then eight data.
// [R19] Incomplete trailing word bits are discarded.
// [R20] Soft reset restores defaults then self-clears.
// [R21] Readback MSB first, aligned with data byte.
// [R22] Register zero write lands at sixteenth edge.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module serial_cfg_device (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  serial_cfg_if.dev       link,
  output logic            low_speed_en,
  output logic [1:0]      ref_sel,
  output logic            standby,
  output logic [3:0]      power_down_mode,
  output logic            readback_mode,
  output logic            parallel_mode
);
  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic       s_rst_pin;
  logic       s_sel_low;
  logic       s_sclk;
  logic       s_shift_data_in;
  logic       sclk_d_r;
  logic       fall;
  logic       rise;

  link_sync #(
    .W    (4),
    .INIT (4'h4)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({link.reset_pin, link.serial_select_low, link.sclk, link.shift_data_in}),
    .q       ({s_rst_pin, s_sel_low, s_sclk, s_shift_data_in})
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= s_sclk;
    end
  end

  assign fall = sclk_d_r & ~s_sclk & ~s_sel_low; // R17
  assign rise = ~sclk_d_r & s_sclk & ~s_sel_low;

  // ****************************************************************
  // Frame receiver
  // ****************************************************************
  logic [3:0]  bit_cnt_r;
  logic [14:0] shift_r;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        soft_rst_r;
  logic        regs_rst;

  // A select pulse restarts the count, so a trailing partial word never commits.
  always_ff @(posedge clk) begin
    if (sys_rst || s_sel_low) begin
      bit_cnt_r <= 4'h0; // R19
    end else if (fall) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= 15'h0000;
    end else if (fall) begin
      shift_r <= {shift_r[13:0], s_shift_data_in}; // R17
    end
  end

  assign wr_en   = fall && (bit_cnt_r == `FRAME_LAST_BIT) && !s_rst_pin; // R22
  assign wr_addr = shift_r[14:7]; // R18
  assign wr_data = {shift_r[6:0], s_shift_data_in}; // R18
  assign regs_rst = sys_rst || s_rst_pin || soft_rst_r; // R14

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst || s_rst_pin) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_en && (wr_addr == `ADDR_RST_RB) && wr_data[`BIT_SOFT_RST]; // R16 R20
    end
  end

  always_ff @(posedge clk) begin
    if (regs_rst) begin
      readback_mode <= 1'b0; // R20
    end else if (wr_en && (wr_addr == `ADDR_RST_RB)) begin
      readback_mode <= wr_data[`BIT_READBACK]; // R1 R3 R16 R22
    end
  end

  always_ff @(posedge clk) begin
    if (regs_rst) begin
      low_speed_en    <= `DEF_LOW_SPEED; // R20
      ref_sel         <= `DEF_REF_SEL;
      standby         <= `DEF_STANDBY;
      power_down_mode <= `DEF_PD_MODE;
    end else if (wr_en && !readback_mode) begin // R2 R3
      case (wr_addr)
        `ADDR_SPEED: begin
          low_speed_en <= wr_data[`BIT_LOW_SPEED];
        end
        `ADDR_REF_STBY: begin
          ref_sel <= wr_data[`BIT_REF_HI:`BIT_REF_LO];
          standby <= wr_data[`BIT_STANDBY];
        end
        `ADDR_PWR_DN: begin
          power_down_mode <= wr_data[`BIT_PD_HI:`BIT_PD_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Readback path
  // ****************************************************************
  logic [7:0] rd_addr;
  logic [7:0] rd_val;
  logic [7:0] rb_sh_r;

  assign rd_addr = {shift_r[6:0], s_shift_data_in}; // R5

  // Register zero yields zeros here: its content is not readable in this mode.
  always_comb begin
    rd_val = 8'h00;
    case (rd_addr)
      `ADDR_SPEED: begin
        rd_val[`BIT_LOW_SPEED] = low_speed_en;
      end
      `ADDR_REF_STBY: begin
        rd_val[`BIT_REF_HI:`BIT_REF_LO] = ref_sel;
        rd_val[`BIT_STANDBY]            = standby;
      end
      `ADDR_PWR_DN: begin
        rd_val[`BIT_PD_HI:`BIT_PD_LO] = power_down_mode;
      end
      default: begin
        rd_val = 8'h00; // R4
      end
    endcase
  end

  // The first bit appears after the address byte; later bits move on rising edges,
  // so each is steady across the falling edge at which the controller takes it.
  always_ff @(posedge clk) begin
    if (regs_rst || !readback_mode || s_sel_low) begin
      rb_sh_r <= 8'h00; // R8
    end else if (fall && (bit_cnt_r == `ADDR_LAST_BIT)) begin
      rb_sh_r <= rd_val; // R6 R9
    end else if (rise && (bit_cnt_r >= `RB_SHIFT_FIRST + 4'h1)) begin
      rb_sh_r <= {rb_sh_r[6:0], 1'b0}; // R21 R7
    end
  end

  assign link.readback_output = rb_sh_r[7]; // R6 R8

  // ****************************************************************
  // Reset pin length watch
  // ****************************************************************
  logic [7:0] rst_len_r;

  always_ff @(posedge clk) begin
    if (sys_rst || !s_rst_pin) begin
      rst_len_r <= 8'h00;
    end else if (rst_len_r != 8'(`RST_LONG_CYC)) begin
      rst_len_r <= rst_len_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      parallel_mode <= 1'b0;
    end else begin
      parallel_mode <= s_rst_pin && (rst_len_r == 8'(`RST_LONG_CYC)); // R12 R15
    end
  end
endmodule

// >>> hw/serial_cfg_if.sv
// Link between the configuration controller and the converter's serial port.
// Assumes the bench connects both ends on this interface.
`timescale 1ns/1ps
interface serial_cfg_if;
  logic sclk;
  logic serial_select_low;
  logic shift_data_in;
  logic readback_output;
  logic reset_pin;

  modport ctrl (
    output sclk,
    output serial_select_low,
    output shift_data_in,
    output reset_pin,
    input  readback_output
  );

  modport dev (
    input  sclk,
    input  serial_select_low,
    input  shift_data_in,
    input  reset_pin,
    output readback_output
  );
endinterface

// >>> hw/serial_cfg_params.svh
// Timing counts, register addresses and field positions of the serial configuration port.
// Assumes a 125 MHz system clock on both ends of the link.
`ifndef SERIAL_CFG_PARAMS_SVH
`define SERIAL_CFG_PARAMS_SVH

// ****************************************************************
// Clock and link timing
// ****************************************************************
`define CLK_PERIOD_NS       8
`define SCLK_HALF_NS        64
`define SCLK_HALF_CYC       ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEN_SETUP_NS        25
`define SEN_SETUP_CYC       ((`SEN_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_NS        100
`define RST_PULSE_CYC       ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_LONG_NS         1000
`define RST_LONG_CYC        (`RST_LONG_NS / `CLK_PERIOD_NS)
`define RST_TO_SEN_NS       100
`define RST_TO_SEN_CYC      ((`RST_TO_SEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// Frame layout
// ****************************************************************
`define FRAME_BITS          16
`define ADDR_LAST_BIT       4'h7
`define FRAME_LAST_BIT      4'hf
`define RB_SHIFT_FIRST      4'h8

// ****************************************************************
// Device register map
// ****************************************************************
`define ADDR_RST_RB         8'h00
`define ADDR_SPEED          8'h20
`define ADDR_REF_STBY       8'h3f
`define ADDR_PWR_DN         8'h40
`define BIT_SOFT_RST        7
`define BIT_READBACK        0
`define BIT_LOW_SPEED       3
`define BIT_REF_HI          6
`define BIT_REF_LO          5
`define BIT_STANDBY         1
`define BIT_PD_HI           3
`define BIT_PD_LO           0
`define DEF_LOW_SPEED       1'h0
`define DEF_REF_SEL         2'h0
`define DEF_STANDBY         1'h0
`define DEF_PD_MODE         4'h0

// ****************************************************************
// Controller APB register map
// ****************************************************************
`define APB_CMD             12'h000
`define APB_CTRL            12'h004
`define APB_STATUS          12'h008
`define CTRL_HW_RST_BIT     0
`define CTRL_PARALLEL_BIT   1
`define STATUS_BUSY_BIT     8

`endif

// >>> hw/serial_cfg_pkg.sv
// Types used by the controller end of the serial configuration port.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_cfg_pkg;

  typedef enum logic [2:0] {
    CTL_IDLE,
    CTL_RST_HIGH,
    CTL_RST_WAIT,
    CTL_SETUP,
    CTL_SHIFT,
    CTL_HOLD
  } ctl_state_t;

endpackage

// >>> sim/serial_config_port_readback_test.sv
// Self-checking bench joining controller and device over the link interface.
// Assumes software reaches the controller over APB with zero wait states allowed.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module serial_config_port_readback_test;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        low_speed_en;
  logic [1:0]  ref_sel;
  logic        standby;
  logic [3:0]  power_down_mode;
  logic        readback_mode;
  logic        parallel_mode;
  logic [31:0] rd;
  logic        err;
  int          errors;
  int          n_tests;

  serial_cfg_if link_if ();
  serial_cfg_ctrl i_serial_cfg_ctrl (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  serial_cfg_device i_serial_cfg_device (.clk(clk), .sys_rst(sys_rst), .link(link_if),
    .low_speed_en(low_speed_en), .ref_sel(ref_sel), .standby(standby),
    .power_down_mode(power_down_mode), .readback_mode(readback_mode), .parallel_mode(parallel_mode));
  serial_link_monitor i_serial_link_monitor (.clk(clk), .sys_rst(sys_rst), .sclk(link_if.sclk),
    .serial_select_low(link_if.serial_select_low), .shift_data_in(link_if.shift_data_in),
    .readback_output(link_if.readback_output), .reset_pin(link_if.reset_pin));

  always #(`CLK_PERIOD_NS / 2) clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task give_up(input string what);
    $display("Error %s expected done seen timeout", what);
    errors++;
    end_of_test();
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  function automatic logic [31:0] fld();
    return {23'h0, low_speed_en, ref_sel, standby, power_down_mode, readback_mode};
  endfunction

  // One APB transfer; read data and error are taken at the edge that sees pready.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (i == 100) give_up("pready");
  endtask

  task wait_idle;
    int i;
    for (i = 0; i < 2000; i++) begin
      apb(1'h0, `APB_STATUS, 32'h0);
      if (rd[`STATUS_BUSY_BIT] === 1'h0) break;
    end
    if (i == 2000) give_up("busy");
  endtask

  task frame(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, `APB_CMD, {16'h0, a, d});
    wait_idle();
  endtask

  task set_all;
    frame(`ADDR_SPEED, 8'h08);
    frame(`ADDR_REF_STBY, 8'h62);
    frame(`ADDR_PWR_DN, 8'h0a);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    check("fields", 32'h0, fld());
    check("readback_output", 32'h0, {31'h0, link_if.readback_output});
    $display("t_reset done");
  endtask

  task t_write;
    set_all();
    check("fields", 32'h1f4, fld());
    apb(1'h0, `APB_CMD, 32'h0);
    check("command word", {16'h0, `ADDR_PWR_DN, 8'h0a}, rd);
    $display("t_write done");
  endtask

  task t_readback;
    logic [7:0] a;
    logic [7:0] e;
    frame(`ADDR_RST_RB, 8'h01);
    check("readback_mode", 32'h1f5, fld());
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? `ADDR_SPEED : (i == 1) ? `ADDR_REF_STBY : `ADDR_PWR_DN;
      e = (i == 0) ? 8'h08 : (i == 1) ? 8'h62 : 8'h0a;
      frame(a, 8'h00);
      apb(1'h0, `APB_STATUS, 32'h0);
      check("readback byte", {24'h0, e}, {24'h0, rd[7:0]});
      check("locked fields", 32'h1f5, fld());
    end
    frame(`ADDR_RST_RB, 8'h01);
    apb(1'h0, `APB_STATUS, 32'h0);
    check("register zero readback", 32'h0, {24'h0, rd[7:0]});
    frame(`ADDR_RST_RB, 8'h00);
    check("exit readback", 32'h1f4, fld());
    frame(`ADDR_SPEED, 8'h00);
    check("write after exit", 32'h0f4, fld());
    $display("t_readback done");
  endtask

  task t_soft;
    frame(`ADDR_RST_RB, 8'h81);
    check("soft reset", 32'h0, fld());
    frame(`ADDR_PWR_DN, 8'h05);
    check("write after soft reset", 32'h00a, fld());
    $display("t_soft done");
  endtask

  task t_hw;
    set_all();
    apb(1'h1, `APB_CTRL, 32'h1);
    wait_idle();
    check("hardware reset", 32'h0, fld());
    apb(1'h0, `APB_CTRL, 32'h0);
    check("pulse bit", 32'h0, rd);
    frame(`ADDR_SPEED, 8'h08);
    check("write after reset", 32'h100, fld());
    $display("t_hw done");
  endtask

  task t_par;
    int i;
    apb(1'h1, `APB_CTRL, 32'h2);
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (parallel_mode === 1'h1) break;
    end
    check("parallel wait", 32'h1, {31'h0, (i >= 125) && (i < 300)});
    apb(1'h1, `APB_CMD, {16'h0, `ADDR_SPEED, 8'h08});
    apb(1'h0, `APB_STATUS, 32'h0);
    check("refused frame", 32'h0, {31'h0, rd[`STATUS_BUSY_BIT]});
    check("held fields", 32'h0, fld());
    apb(1'h0, `APB_CTRL, 32'h0);
    check("parallel bit", 32'h2, rd);
    apb(1'h1, `APB_CTRL, 32'h0);
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (parallel_mode === 1'h0) break;
    end
    check("parallel release", 32'h0, {31'h0, parallel_mode});
    wait_idle();
    frame(`ADDR_PWR_DN, 8'h03);
    check("serial again", 32'h006, fld());
    $display("t_par done");
  endtask

  task t_apb;
    apb(1'h0, 12'h00c, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    apb(1'h0, `APB_STATUS, 32'h0);
    check("mapped error", 32'h0, {31'h0, err});
    $display("t_apb done");
  endtask

  initial begin
    clk     = 1'h0;
    sys_rst = 1'h1;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    errors  = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_write();
    t_readback();
    t_soft();
    t_hw();
    t_par();
    t_apb();
    end_of_test();
  end
endmodule

// >>> sim/serial_link_monitor.sv
// Concurrent checks on the serial configuration link between the two ends.
// Assumes it watches the interface signals directly, sampled on the system clock.
`timescale 1ns/1ps
`include "serial_cfg_params.svh"
module serial_link_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic serial_select_low,
  input wire logic shift_data_in,
  input wire logic readback_output,
  input wire logic reset_pin
);
  logic       sclk_r;
  logic [4:0] falls_r;
  logic [7:0] gap_r;
  logic [7:0] hi_r;

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  always_ff @(posedge clk) begin
    sclk_r <= sys_rst ? 1'h0 : sclk;
  end

  // Counts link clock falls within one select-low period.
  always_ff @(posedge clk) begin
    if (sys_rst || serial_select_low) begin
      falls_r <= 5'h0;
    end else if (sclk_r && !sclk) begin
      falls_r <= falls_r + 5'h1;
    end
  end

  // Counts cycles since the reset pin was last released.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_r <= 8'hff;
    end else if (reset_pin) begin
      gap_r <= 8'h0;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !reset_pin) begin
      hi_r <= 8'h0;
    end else if (hi_r != 8'hff) begin
      hi_r <= hi_r + 8'h1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence select_idle_s;
    serial_select_low [*4];
  endsequence

  sequence clock_high_s;
    sclk [*8] ##1 !sclk;
  endsequence

  idle_clock_low_a: assert property (serial_select_low |-> !sclk)
    else $error("link clock moved outside a frame");
  select_setup_a: assert property ($fell(serial_select_low) |-> !sclk [*4])
    else $error("link clock rose too soon after select");
  clock_half_a: assert property ($rose(sclk) |-> clock_high_s)
    else $error("link clock high phase has wrong length");
  data_stable_a: assert property (!serial_select_low && sclk_r |-> $stable(shift_data_in))
    else $error("serial data changed around a falling link clock edge");
  frame_length_a: assert property ($rose(serial_select_low) |-> falls_r == 5'h10)
    else $error("frame did not carry sixteen bits");
  readback_idle_a: assert property (select_idle_s |-> !readback_output)
    else $error("readback output not low outside a frame");
  reset_gap_a: assert property (!serial_select_low |-> gap_r >= `RST_TO_SEN_CYC)
    else $error("select asserted too soon after reset release");
  reset_width_a: assert property ($fell(reset_pin) |-> hi_r >= 8'h02)
    else $error("reset pulse too short");
  reset_quiet_a: assert property (reset_pin |-> serial_select_low)
    else $error("frame sent while reset pin high");
endmodule
